// *** hw/sli_pkg.sv ***
package sli_pkg;

    // time base
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_MIN    = 60000;

    // flash timing in ms
    localparam logic [12:0] PER_5HZ_MS   = 13'd200;
    localparam logic [12:0] PER_2HZ_MS   = 13'd500;
    localparam logic [12:0] PER_1S_MS    = 13'd2000;
    localparam logic [12:0] PER_2S_MS    = 13'd4000;
    localparam logic [12:0] ON_5HZ_MS    = 13'd100;
    localparam logic [12:0] ON_2HZ_MS    = 13'd250;
    localparam logic [12:0] ON_1S_MS     = 13'd1000;
    localparam logic [12:0] ON_2S_MS     = 13'd2000;
    localparam logic [12:0] PER_IDLE_MS  = 13'd1;
    localparam logic [7:0]  PKT_FLASH_MS = 8'd50;

    // time-out setting codes
    localparam logic [7:0] TMO_NEVER    = 8'hff;
    localparam logic [7:0] TMO_DISABLED = 8'h00;
    localparam logic [7:0] TMO_END_DEV  = 8'h01;
    localparam logic [7:0] TMO_RESET    = 8'hff;

    // role codes
    localparam logic [1:0] ROLE_GATEWAY = 2'h0;
    localparam logic [1:0] ROLE_ROUTER  = 2'h1;
    localparam logic [1:0] ROLE_END_DEV = 2'h2;
    localparam logic [1:0] ROLE_RESET   = 2'h1;

    // link state codes from the mesh stack
    localparam logic [2:0] LINK_NONE      = 3'h0;
    localparam logic [2:0] LINK_GW_MULTI  = 3'h1;
    localparam logic [2:0] LINK_GW_SINGLE = 3'h2;
    localparam logic [2:0] LINK_RT_MULTI  = 3'h3;
    localparam logic [2:0] LINK_RT_SINGLE = 3'h4;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
    localparam logic [7:0] ADDR_THRESH  = 8'h08;
    localparam logic [7:0] ADDR_PINNED  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;

    // ctrl fields
    localparam int CTRL_ROLE_LSB = 0;
    localparam int CTRL_CFG_BIT  = 2;

    // reset values
    localparam logic [7:0]  TOP_RESET    = 8'hc0;
    localparam logic [7:0]  ACCEPT_RESET = 8'h60;
    localparam logic [7:0]  MARGIN_RESET = 8'h10;
    localparam logic [31:0] PINNED_RESET = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] margin;
        logic [7:0] accept;
        logic [7:0] top;
    } sli_thresh_t;

    typedef enum logic [2:0] {
        PAT_OFF,
        PAT_ON,
        PAT_5HZ,
        PAT_2HZ,
        PAT_1S,
        PAT_2S
    } sli_pat_t;

endpackage

// *** hw/sli_status_led.sv ***
`timescale 1ns/100ps

module sli_status_led #(
    parameter int unsigned CYCLES_PER_MS = sli_pkg::CYCLES_PER_MS,
    parameter int unsigned MS_PER_MIN    = sli_pkg::MS_PER_MIN
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // radio and mesh state
    input  wire logic [7:0]  signalLevel,
    input  wire logic [2:0]  linkState,
    input  wire logic        txPacket,
    input  wire logic        rxGoodPacket,
    input  wire logic        pulseDetect,
    // indicator outputs
    output logic             signal_tx_lamp,
    output logic             link_rx_lamp,
    output logic             pulseFeedback
);

    // registers
    logic [1:0]          role_q;
    logic                cfgMode_q;
    logic [7:0]          timeout_q;
    sli_pkg::sli_thresh_t thresh_q;
    logic [31:0]         pinned_target_id_q;

    // bus state
    logic                awFull_q;
    logic                wFull_q;
    logic [7:0]          awAddr_q;
    logic [31:0]         wData_q;
    logic [3:0]          wStrb_q;
    logic                wrFire;

    // time base
    logic [15:0]         cycCnt_q;
    logic                msTick_q;
    logic [15:0]         msCnt_q;
    logic [7:0]          minutes_q;
    logic                expired_q;
    logic                active;

    // patterns
    sli_pkg::sli_pat_t   sigPat;
    sli_pkg::sli_pat_t   linkPat;
    sli_pkg::sli_pat_t   sigPatPrev_q;
    sli_pkg::sli_pat_t   linkPatPrev_q;
    logic [12:0]         sigPhase_q;
    logic [12:0]         linkPhase_q;
    logic [7:0]          txStretch_q;
    logic [7:0]          rxStretch_q;
    logic [7:0]          pulseStretch_q;
    logic                sigLamp_d;
    logic                linkLamp_d;

    function automatic logic [31:0] mergeStrb(input logic [31:0] oldV,
                                              input logic [31:0] newV,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = oldV;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = newV[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [12:0] patPeriod(input sli_pkg::sli_pat_t p);
        case (p)
            sli_pkg::PAT_5HZ: patPeriod = sli_pkg::PER_5HZ_MS;
            sli_pkg::PAT_2HZ: patPeriod = sli_pkg::PER_2HZ_MS;
            sli_pkg::PAT_1S:  patPeriod = sli_pkg::PER_1S_MS;
            sli_pkg::PAT_2S:  patPeriod = sli_pkg::PER_2S_MS;
            default:          patPeriod = sli_pkg::PER_IDLE_MS;
        endcase
    endfunction

    function automatic logic patLevel(input sli_pkg::sli_pat_t p, input logic [12:0] ph);
        case (p)
            sli_pkg::PAT_ON:  patLevel = 1'b1;
            sli_pkg::PAT_5HZ: patLevel = ph < sli_pkg::ON_5HZ_MS;
            sli_pkg::PAT_2HZ: patLevel = ph < sli_pkg::ON_2HZ_MS;
            sli_pkg::PAT_1S:  patLevel = ph < sli_pkg::ON_1S_MS;
            sli_pkg::PAT_2S:  patLevel = ph < sli_pkg::ON_2S_MS;
            default:          patLevel = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] stretch(input logic [7:0] cnt,
                                           input logic       ev,
                                           input logic       tick);
        if (ev) begin
            stretch = sli_pkg::PKT_FLASH_MS;
        end else if (tick && cnt != 8'h00) begin
            stretch = cnt - 8'h01;
        end else begin
            stretch = cnt;
        end
    endfunction

    // bus write channels, taken in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awFull_q <= 1'b0;
            wFull_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            awready  <= 1'b1;
            wready   <= 1'b1;
            bvalid   <= 1'b0;
            bresp    <= sli_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awFull_q <= 1'b1;
                awAddr_q <= awaddr;
                awready  <= 1'b0;
            end
            if (wvalid && wready) begin
                wFull_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
                wready  <= 1'b0;
            end
            if (wrFire) begin
                awFull_q <= 1'b0;
                wFull_q  <= 1'b0;
                bvalid   <= 1'b1;
                case (awAddr_q)
                    sli_pkg::ADDR_CTRL,
                    sli_pkg::ADDR_TIMEOUT,
                    sli_pkg::ADDR_THRESH,
                    sli_pkg::ADDR_PINNED,
                    sli_pkg::ADDR_STATUS: bresp <= sli_pkg::RESP_OKAY;
                    default:              bresp <= sli_pkg::RESP_SLVERR;
                endcase
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    assign wrFire = awFull_q && wFull_q && !bvalid;

    // software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            role_q             <= sli_pkg::ROLE_RESET;
            cfgMode_q          <= 1'b0;
            timeout_q          <= sli_pkg::TMO_RESET;
            thresh_q           <= '{margin: sli_pkg::MARGIN_RESET,
                                    accept: sli_pkg::ACCEPT_RESET,
                                    top:    sli_pkg::TOP_RESET};
            pinned_target_id_q <= sli_pkg::PINNED_RESET;
        end else if (wrFire) begin
            case (awAddr_q)
                sli_pkg::ADDR_CTRL: begin
                    if (wStrb_q[0]) begin
                        role_q    <= wData_q[sli_pkg::CTRL_ROLE_LSB +: 2];
                        cfgMode_q <= wData_q[sli_pkg::CTRL_CFG_BIT];
                        if (wData_q[sli_pkg::CTRL_ROLE_LSB +: 2] == sli_pkg::ROLE_END_DEV
                            && role_q != sli_pkg::ROLE_END_DEV) begin
                            timeout_q <= sli_pkg::TMO_END_DEV;
                        end
                    end
                end
                sli_pkg::ADDR_TIMEOUT: begin
                    if (wStrb_q[0]) begin
                        timeout_q <= wData_q[7:0];
                    end
                end
                sli_pkg::ADDR_THRESH: begin
                    thresh_q <= 24'(
                        mergeStrb({8'h00, thresh_q}, wData_q, wStrb_q)
                    );
                end
                sli_pkg::ADDR_PINNED: begin
                    pinned_target_id_q <= mergeStrb(pinned_target_id_q, wData_q, wStrb_q);
                end
                default: begin
                end
            endcase
        end
    end

    // bus read channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= sli_pkg::RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= sli_pkg::RESP_OKAY;
                case (araddr)
                    sli_pkg::ADDR_CTRL:    rdata <= {29'h0, cfgMode_q, role_q};
                    sli_pkg::ADDR_TIMEOUT: rdata <= {24'h0, timeout_q};
                    sli_pkg::ADDR_THRESH:  rdata <= {8'h00, thresh_q};
                    sli_pkg::ADDR_PINNED:  rdata <= pinned_target_id_q;
                    sli_pkg::ADDR_STATUS:  rdata <= {8'h00, 1'b0, sigPat, 1'b0, linkPat,
                                                     minutes_q, 4'h0, active, pulseFeedback,
                                                     link_rx_lamp, signal_tx_lamp};
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= sli_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // millisecond tick, free running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cycCnt_q <= 16'h0000;
            msTick_q <= 1'b0;
        end else if (cycCnt_q == 16'(CYCLES_PER_MS - 1)) begin
            cycCnt_q <= 16'h0000;
            msTick_q <= 1'b1;
        end else begin
            cycCnt_q <= cycCnt_q + 16'h0001;
            msTick_q <= 1'b0;
        end
    end

    // minutes since reset, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msCnt_q   <= 16'h0000;
            minutes_q <= 8'h00;
        end else if (msTick_q) begin
            if (msCnt_q == 16'(MS_PER_MIN - 1)) begin
                msCnt_q <= 16'h0000;
                if (minutes_q != 8'hff) begin
                    minutes_q <= minutes_q + 8'h01;
                end
            end else begin
                msCnt_q <= msCnt_q + 16'h0001;
            end
        end
    end

    // expiry is sticky: a later larger setting cannot revive the lamps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            expired_q <= 1'b0;
        end else if (timeout_q == sli_pkg::TMO_DISABLED) begin
            expired_q <= 1'b1;
        end else if (timeout_q != sli_pkg::TMO_NEVER && minutes_q >= timeout_q) begin
            expired_q <= 1'b1;
        end
    end

    assign active = !expired_q;

    // pattern selection
    always_comb begin
        if (signalLevel > thresh_q.top) begin
            sigPat = sli_pkg::PAT_5HZ;
        end else if ({1'b0, signalLevel} >= {1'b0, thresh_q.accept} + {1'b0, thresh_q.margin}) begin
            sigPat = sli_pkg::PAT_2HZ;
        end else if (signalLevel >= thresh_q.accept) begin
            sigPat = sli_pkg::PAT_1S;
        end else begin
            sigPat = sli_pkg::PAT_2S;
        end
    end

    always_comb begin
        case (linkState)
            sli_pkg::LINK_GW_MULTI:  linkPat = sli_pkg::PAT_ON;
            sli_pkg::LINK_GW_SINGLE: linkPat = sli_pkg::PAT_5HZ;
            sli_pkg::LINK_RT_MULTI:  linkPat = sli_pkg::PAT_2HZ;
            sli_pkg::LINK_RT_SINGLE: linkPat = sli_pkg::PAT_1S;
            default:                 linkPat = sli_pkg::PAT_OFF;
        endcase
    end

    // phase counters restart from zero on any pattern change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sigPatPrev_q <= sli_pkg::PAT_OFF;
            sigPhase_q   <= 13'h0000;
        end else begin
            sigPatPrev_q <= sigPat;
            if (sigPat != sigPatPrev_q) begin
                sigPhase_q <= 13'h0000;
            end else if (msTick_q) begin
                sigPhase_q <= (sigPhase_q >= patPeriod(sigPat) - 13'h0001) ? 13'h0000
                            : sigPhase_q + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            linkPatPrev_q <= sli_pkg::PAT_OFF;
            linkPhase_q   <= 13'h0000;
        end else begin
            linkPatPrev_q <= linkPat;
            if (linkPat != linkPatPrev_q) begin
                linkPhase_q <= 13'h0000;
            end else if (msTick_q) begin
                linkPhase_q <= (linkPhase_q >= patPeriod(linkPat) - 13'h0001) ? 13'h0000
                             : linkPhase_q + 13'h0001;
            end
        end
    end

    // packet and pulse flash stretchers; a new event retriggers the flash
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txStretch_q    <= 8'h00;
            rxStretch_q    <= 8'h00;
            pulseStretch_q <= 8'h00;
        end else begin
            txStretch_q    <= stretch(txStretch_q, txPacket, msTick_q);
            rxStretch_q    <= stretch(rxStretch_q, rxGoodPacket, msTick_q);
            pulseStretch_q <= stretch(pulseStretch_q, pulseDetect, msTick_q);
        end
    end

    // lamp levels, priority: time-out, config mode, role
    always_comb begin
        if (!active) begin
            sigLamp_d  = 1'b0;
            linkLamp_d = 1'b0;
        end else if (cfgMode_q) begin
            sigLamp_d  = 1'b1;
            linkLamp_d = 1'b1;
        end else if (role_q == sli_pkg::ROLE_GATEWAY) begin
            sigLamp_d  = txStretch_q != 8'h00;
            linkLamp_d = rxStretch_q != 8'h00;
        end else begin
            sigLamp_d = patLevel(sigPat, sigPhase_q);
            if (pinned_target_id_q != sli_pkg::PINNED_RESET) begin
                linkLamp_d = patLevel(sigPat, sigPhase_q);
            end else begin
                linkLamp_d = patLevel(linkPat, linkPhase_q);
            end
        end
    end

    // outputs source current: high lights the lamp
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            signal_tx_lamp <= 1'b0;
            link_rx_lamp   <= 1'b0;
            pulseFeedback  <= 1'b0;
        end else begin
            signal_tx_lamp <= sigLamp_d;
            link_rx_lamp   <= linkLamp_d;
            pulseFeedback  <= active && pulseStretch_q != 8'h00;
        end
    end

endmodule

// *** testbench/sli_lamp_watch.sv ***
`timescale 1ns/100ps
module sli_lamp_watch (
    // clock
    input  wire logic   clk,
    // watched lamp
    input  wire logic   lamp,
    // last lit run and number of runs seen
    output logic [15:0] runLen,
    output logic [15:0] falls
);
    logic [15:0] run_q = 16'h0000;
    initial runLen = 16'h0000;
    initial falls  = 16'h0000;
    // a lamp counts as lit only while high; a sinking hookup would read inverted
    always @(posedge clk) begin
        if (lamp) begin
            run_q <= run_q + 16'h0001;
        end else if (run_q != 16'h0000) begin
            runLen <= run_q;
            falls  <= falls + 16'h0001;
            run_q  <= 16'h0000;
        end
    end
endmodule

// *** testbench/sli_status_led_props.sv ***
`timescale 1ns/100ps
module sli_status_led_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register bus
    input wire logic [7:0]  awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    // events and lamps
    input wire logic        txPacket,
    input wire logic        rxGoodPacket,
    input wire logic        pulseDetect,
    input wire logic        signal_tx_lamp,
    input wire logic        link_rx_lamp,
    input wire logic        pulseFeedback
);
    logic [1:0] role_q;
    logic       cfg_q;
    logic [1:0] gwHist_q;
    wire        gwMode = role_q == sli_pkg::ROLE_GATEWAY && !cfg_q;
    wire        gwOk   = gwMode && gwHist_q == 2'b11;
    wire        ctrlWr = awvalid && awready && wvalid && wready && wstrb[0];

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // tracking assumes address and data are taken on one edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            role_q <= sli_pkg::ROLE_RESET;
            cfg_q  <= 1'b0;
        end else if (ctrlWr && awaddr == sli_pkg::ADDR_CTRL) begin
            role_q <= wdata[1:0];
            cfg_q  <= wdata[2];
        end
    end
    // settle time so a flash left over from the old role is not judged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gwHist_q <= 2'b00;
        else gwHist_q <= {gwHist_q[0], gwMode};
    end

    a_cfg_both_lit:
        assert property (cfg_q && $past(cfg_q, 3) && (signal_tx_lamp || link_rx_lamp)
            |-> signal_tx_lamp && link_rx_lamp) else $error("config lamps not both lit");
    a_tx_flash_cause:
        assert property (gwOk && $rose(signal_tx_lamp) |-> $past(txPacket) || $past(txPacket, 2))
            else $error("tx lamp lit without packet");
    a_rx_flash_cause:
        assert property (gwOk && $rose(link_rx_lamp)
            |-> $past(rxGoodPacket) || $past(rxGoodPacket, 2)) else $error("rx lamp lit alone");
    a_tx_flash_hold:
        assert property (gwOk && $rose(signal_tx_lamp) |-> signal_tx_lamp [*8])
            else $error("tx flash too short");
    a_fb_pulse_cause:
        assert property ($rose(pulseFeedback) |-> $past(pulseDetect) || $past(pulseDetect, 2))
            else $error("feedback without pulse");
    a_fb_pulse_hold:
        assert property ($rose(pulseFeedback) |-> pulseFeedback [*8])
            else $error("feedback pulse too short");
    a_write_answer:
        assert property (ctrlWr |-> ##2 bvalid) else $error("write response late");
    a_read_answer:
        assert property (arvalid && arready |=> rvalid) else $error("read data late");
    a_aw_refused:
        assert property (bvalid |-> !awready && !wready) else $error("ready during response");

    cover property (gwOk && $rose(signal_tx_lamp));
    cover property (cfg_q && signal_tx_lamp && link_rx_lamp);
    cover property ($rose(pulseFeedback));
endmodule

bind sli_status_led sli_status_led_props u_props (
    .clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid,
    .arvalid, .arready, .rvalid, .txPacket, .rxGoodPacket, .pulseDetect, .signal_tx_lamp,
    .link_rx_lamp, .pulseFeedback);

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    localparam int CPM = 2;
    localparam int MPM = 500;
    typedef struct packed {
        logic [7:0]        sig;
        logic [2:0]        link;
        sli_pkg::sli_pat_t sp;
        sli_pkg::sli_pat_t lp;
        logic              m;
    } sli_row_t;
    logic        clk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, signalLevel = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        txPacket = 1'b0, rxGoodPacket = 1'b0, pulseDetect = 1'b0;
    logic [2:0]  linkState = 3'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        signal_tx_lamp, link_rx_lamp, pulseFeedback;
    logic [1:0]  bresp, rresp, resp;
    logic [15:0] len [3];
    logic [15:0] falls [3];
    int          fail_count = 0, num_checks = 0;
    sli_row_t    rows [7];

    always #25 clk = ~clk;

    sli_status_led #(.CYCLES_PER_MS(CPM), .MS_PER_MIN(MPM)) DUT (
        .clk, .rst, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .signalLevel, .linkState, .txPacket,
        .rxGoodPacket, .pulseDetect, .signal_tx_lamp, .link_rx_lamp, .pulseFeedback);
    sli_lamp_watch u_sig (.clk, .lamp(signal_tx_lamp), .runLen(len[0]), .falls(falls[0]));
    sli_lamp_watch u_lnk (.clk, .lamp(link_rx_lamp), .runLen(len[1]), .falls(falls[1]));
    sli_lamp_watch u_fb (.clk, .lamp(pulseFeedback), .runLen(len[2]), .falls(falls[2]));

    task automatic results();
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    task automatic doReset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    // waits without limit; only the watchdog ends a hung handshake
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic go;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        go = 1'b1;
        while (go) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                go = 1'b0;
            end
        end
    endtask
    task automatic axr(input logic [7:0] a);
        logic go;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        go = 1'b1;
        while (go) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                go = 1'b0;
            end
        end
    endtask
    function automatic logic [12:0] onMs(input sli_pkg::sli_pat_t p);
        case (p)
            sli_pkg::PAT_5HZ: return sli_pkg::ON_5HZ_MS;
            sli_pkg::PAT_2HZ: return sli_pkg::ON_2HZ_MS;
            sli_pkg::PAT_1S:  return sli_pkg::ON_1S_MS;
            sli_pkg::PAT_2S:  return sli_pkg::ON_2S_MS;
            default:          return 13'h0000;
        endcase
    endfunction
    // n lit runs must end; the first after a change may be a leftover
    task automatic meas(input int n, input logic [12:0] s, l, f);
        logic [12:0] ms [3];
        logic [15:0] f0 [3];
        logic        busy;
        ms = '{s, l, f};
        f0 = falls;
        do begin
            @(posedge clk);
            busy = 1'b0;
            for (int k = 0; k < 3; k++) if (ms[k] != 0 && falls[k] < f0[k] + n) busy = 1'b1;
        end while (busy);
        for (int k = 0; k < 3; k++) if (ms[k] != 0) check("lampOn", 32'(len[k]), ms[k] * CPM);
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        results();
    end

    initial begin
        rows = '{'{8'hd0, 3'h2, sli_pkg::PAT_5HZ, sli_pkg::PAT_5HZ, 1'b1},
                 '{8'hc0, 3'h3, sli_pkg::PAT_2HZ, sli_pkg::PAT_2HZ, 1'b1},
                 '{8'h6f, 3'h4, sli_pkg::PAT_1S, sli_pkg::PAT_1S, 1'b1},
                 '{8'h5f, 3'h0, sli_pkg::PAT_2S, sli_pkg::PAT_OFF, 1'b1},
                 '{8'h70, 3'h1, sli_pkg::PAT_2HZ, sli_pkg::PAT_ON, 1'b0},
                 '{8'h60, 3'h7, sli_pkg::PAT_1S, sli_pkg::PAT_OFF, 1'b0},
                 '{8'hc1, 3'h2, sli_pkg::PAT_5HZ, sli_pkg::PAT_5HZ, 1'b0}};
        doReset();
        axr(sli_pkg::ADDR_CTRL);
        check("ctrlRst", rd, {30'h0, sli_pkg::ROLE_RESET});
        axr(sli_pkg::ADDR_TIMEOUT);
        check("tmoRst", rd, {24'h0, sli_pkg::TMO_RESET});
        axr(sli_pkg::ADDR_THRESH);
        check("thrRst", rd, {8'h0, sli_pkg::MARGIN_RESET, sli_pkg::ACCEPT_RESET, sli_pkg::TOP_RESET});
        foreach (rows[i]) begin
            signalLevel <= rows[i].sig;
            linkState <= rows[i].link;
            repeat (8) @(posedge clk);
            axr(sli_pkg::ADDR_STATUS);
            check("sigPat", rd[22:20], rows[i].sp);
            check("linkPat", rd[18:16], rows[i].lp);
            if (rows[i].m) meas(2, onMs(rows[i].sp), onMs(rows[i].lp), 13'h0);
            if (rows[i].lp inside {sli_pkg::PAT_ON, sli_pkg::PAT_OFF})
                check("linkLvl", link_rx_lamp, rows[i].lp == sli_pkg::PAT_ON);
        end
        axw(sli_pkg::ADDR_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        check("cfgOn", {signal_tx_lamp, link_rx_lamp}, 2'b11);
        repeat (300) @(posedge clk);
        check("cfgHold", {signal_tx_lamp, link_rx_lamp}, 2'b11);
        axw(sli_pkg::ADDR_CTRL, 32'h1);
        axr(sli_pkg::ADDR_STATUS);
        check("cfgExit", rd[22:20], sli_pkg::PAT_5HZ);
        linkState <= 3'h0;
        axw(sli_pkg::ADDR_PINNED, 32'h0000_1234);
        meas(2, sli_pkg::ON_5HZ_MS, sli_pkg::ON_5HZ_MS, 13'h0);
        axw(sli_pkg::ADDR_PINNED, 32'h0);
        axw(sli_pkg::ADDR_CTRL, 32'h0);
        @(posedge clk iff DUT.msTick_q);
        @(posedge clk);
        txPacket <= 1'b1;
        rxGoodPacket <= 1'b1;
        pulseDetect <= 1'b1;
        @(posedge clk);
        txPacket <= 1'b0;
        rxGoodPacket <= 1'b0;
        pulseDetect <= 1'b0;
        meas(1, 13'(sli_pkg::PKT_FLASH_MS), 13'(sli_pkg::PKT_FLASH_MS), 13'(sli_pkg::PKT_FLASH_MS));
        axw(8'h20, 32'h1);
        check("wrErr", resp, sli_pkg::RESP_SLVERR);
        axr(8'h20);
        check("rdErr", resp, sli_pkg::RESP_SLVERR);
        check("rdZero", rd, 32'h0);
        doReset();
        axw(sli_pkg::ADDR_CTRL, 32'h2);
        axr(sli_pkg::ADDR_TIMEOUT);
        check("edTmo", rd, {24'h0, sli_pkg::TMO_END_DEV});
        repeat (MPM * CPM - 200) @(posedge clk);
        axr(sli_pkg::ADDR_STATUS);
        check("active", rd[3], 1'b1);
        repeat (400) @(posedge clk);
        axr(sli_pkg::ADDR_STATUS);
        check("expired", rd[3:0], 4'h0);
        axw(sli_pkg::ADDR_TIMEOUT, 32'hff);
        pulseDetect <= 1'b1;
        @(posedge clk);
        pulseDetect <= 1'b0;
        repeat (8) @(posedge clk);
        check("staysDark", {pulseFeedback, signal_tx_lamp, link_rx_lamp}, 3'h0);
        doReset();
        axw(sli_pkg::ADDR_TIMEOUT, 32'h0);
        axw(sli_pkg::ADDR_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        check("zeroOff", {signal_tx_lamp, link_rx_lamp}, 2'b00);
        results();
    end
endmodule
